// ===== hdl/boot_mode_consts.svh
// Constants of the reset-time boot mode selection logic.
// Assumes a 20 MHz system clock and a 24-bit, 16-bit wide flash read port.
`ifndef BOOT_MODE_CONSTS_SVH
`define BOOT_MODE_CONSTS_SVH

// ====================================================================
// Clock and timing.
`define CLK_FREQ_MHZ      20
`define UART_START_NS     1000
`define CAN_DOMINANT_NS   2000
`define UART_START_CYC    (((`UART_START_NS * `CLK_FREQ_MHZ) + 999) / 1000)
`define CAN_DOMINANT_CYC  (((`CAN_DOMINANT_NS * `CLK_FREQ_MHZ) + 999) / 1000)
`define LOW_CNT_W         8

// ====================================================================
// Boot configuration field in the low configuration port.
`define CFG_HI_BIT        5
`define CFG_LO_BIT        4
`define CFG_USER          2'h3
`define CFG_STD_BOOT      2'h2
`define CFG_SEL_BOOT      2'h1
`define CFG_RESERVED      2'h0

// ====================================================================
// Flash locations and values used by the selective boot check.
`define FLASH_ADDR_W      24
`define FLASH_DATA_W      16
`define SIG_ADDR0         24'h00_1ff0
`define SIG_ADDR1         24'h00_1ff2
`define KEY_ADDR          24'h00_1ff4
`define SIG_REFERENCE     16'h5aa5
`define KEY_STD_BOOT      16'h0001
`define KEY_UART_ONLY     16'h0002
`define KEY_CAN_ONLY      16'h0003

`endif

// ===== hdl/boot_mode_pkg.sv
// Types shared by the boot mode selection modules.
// Assumes boot_mode_consts.svh is on the include path.
`include "boot_mode_consts.svh"

package boot_mode_pkg;

  // ==================================================================
  // Captured boot mode.
  typedef enum logic [1:0] {
    MODE_RESERVED = `CFG_RESERVED,
    MODE_SEL_BOOT = `CFG_SEL_BOOT,
    MODE_STD_BOOT = `CFG_STD_BOOT,
    MODE_USER     = `CFG_USER
  } boot_mode_e;

  // ==================================================================
  // Sequencer and signature checker states.
  typedef enum logic [3:0] {
    ST_WAIT_RST  = 4'h0,
    ST_DECODE    = 4'h1,
    ST_SIG_CHECK = 4'h3,
    ST_SCAN      = 4'h2,
    ST_UART_BOOT = 4'h6,
    ST_CAN_BOOT  = 4'h7,
    ST_SW_RESET  = 4'h4,
    ST_USER_RUN  = 4'h5,
    ST_HALT_LOOP = 4'hc,
    ST_RESERVED  = 4'hd
  } seq_state_e;

  typedef enum logic [2:0] {
    CHK_IDLE = 3'h0,
    CHK_RD0  = 3'h1,
    CHK_RD1  = 3'h3,
    CHK_KEY  = 3'h2,
    CHK_DONE = 3'h6
  } chk_state_e;

endpackage : boot_mode_pkg

// ===== hdl/sig_check_if.sv
// Control carrier between the boot sequencer and the signature checker.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

interface sig_check_if;
  logic                     start;
  logic                     done;
  logic                     pass;
  logic [`FLASH_DATA_W-1:0] key;

  modport ctrl (output start, input done, input pass, input key);
  modport chk  (input start, output done, output pass, output key);
endinterface : sig_check_if

// ===== hdl/line_start_detector.sv
// Detects a receive line held low for a least number of cycles.
// Assumes the line is synchronous to clk and idles high.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

module line_start_detector #(
  parameter logic [`LOW_CNT_W-1:0] MIN_LOW = 8'h14
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Line and control.
  input  wire logic enable,
  input  wire logic rx_line,
  output logic      detected
);

  logic [`LOW_CNT_W-1:0] low_cnt_ff;

  // ==================================================================
  // Low-time counter; one report per low period.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_ff <= '0;
    end else if (!enable || rx_line) begin
      low_cnt_ff <= '0;
    end else if (low_cnt_ff != MIN_LOW) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  assign detected = enable && !rx_line && (low_cnt_ff == MIN_LOW - 8'h01);

  chk_detect_low_run: assert property (
    @(posedge clk) disable iff (reset)
    detected |-> $past(!rx_line && enable))
    else $error("detection without a low line");

endmodule : line_start_detector

// ===== hdl/signature_checker.sv
// Reads the two signature words and, on mismatch, the user key.
// Assumes a flash port that answers a held request with a valid pulse.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

module signature_checker (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Control from the sequencer.
  sig_check_if.chk                      ctl,
  // Flash read port.
  output logic                          flash_rd_req,
  output logic [`FLASH_ADDR_W-1:0]      flash_rd_addr,
  input  wire logic [`FLASH_DATA_W-1:0] flash_rd_data,
  input  wire logic                     flash_rd_valid
);

  boot_mode_pkg::chk_state_e state_ff;
  logic [`FLASH_DATA_W-1:0]  word0_ff;

  // Signature of the two reserved words.
  function automatic logic [`FLASH_DATA_W-1:0] sig_calc(
    input logic [`FLASH_DATA_W-1:0] a,
    input logic [`FLASH_DATA_W-1:0] b);
    sig_calc = a ^ {b[7:0], b[15:8]};
  endfunction : sig_calc

  // ==================================================================
  // Read sequence.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff      <= boot_mode_pkg::CHK_IDLE;
      word0_ff      <= '0;
      flash_rd_addr <= '0;
      ctl.pass      <= 1'b0;
      ctl.key       <= '0;
    end else begin
      unique case (state_ff)
        boot_mode_pkg::CHK_IDLE: begin
          if (ctl.start) begin
            state_ff      <= boot_mode_pkg::CHK_RD0;
            flash_rd_addr <= `SIG_ADDR0;
            ctl.pass      <= 1'b0;
          end
        end
        boot_mode_pkg::CHK_RD0: begin
          if (flash_rd_valid) begin
            word0_ff      <= flash_rd_data;
            state_ff      <= boot_mode_pkg::CHK_RD1;
            flash_rd_addr <= `SIG_ADDR1;
          end
        end
        boot_mode_pkg::CHK_RD1: begin
          if (flash_rd_valid) begin
            if (sig_calc(word0_ff, flash_rd_data) ==
                `SIG_REFERENCE) begin
              ctl.pass <= 1'b1;
              state_ff <= boot_mode_pkg::CHK_DONE;
            end else begin
              state_ff      <= boot_mode_pkg::CHK_KEY;
              flash_rd_addr <= `KEY_ADDR;
            end
          end
        end
        boot_mode_pkg::CHK_KEY: begin
          if (flash_rd_valid) begin
            ctl.key  <= flash_rd_data;
            state_ff <= boot_mode_pkg::CHK_DONE;
          end
        end
        boot_mode_pkg::CHK_DONE: state_ff <= boot_mode_pkg::CHK_IDLE;
        default: state_ff <= boot_mode_pkg::CHK_IDLE;
      endcase
    end
  end

  assign flash_rd_req = (state_ff == boot_mode_pkg::CHK_RD0) ||
                        (state_ff == boot_mode_pkg::CHK_RD1) ||
                        (state_ff == boot_mode_pkg::CHK_KEY);
  assign ctl.done     = (state_ff == boot_mode_pkg::CHK_DONE);

  chk_req_held_stable: assert property (
    @(posedge clk) disable iff (reset)
    flash_rd_req && !flash_rd_valid |=> flash_rd_req && $stable(flash_rd_addr))
    else $error("flash request dropped or moved before answer");

endmodule : signature_checker

// ===== hdl/boot_mode_selector.sv
// Reset-time boot mode selection and bootstrap channel entry.
// Assumes all pins synchronous to clk; the flash port answers reads.
//
// Overview of operation
// - Latch config bits 5..4 at reset release.
// - Code 11: user mode, user flash fetches.
// - Code 10: standard boot, fetches from test flash.
// - Code 01: selective boot; code 00 reserved.
// - Selective boot compares two-word signature with reference.
// - Signature good: software reset, then user code.
// - Signature bad: key picks loader, UART, CAN, loop.
// - Standard boot watches UART and CAN receive lines.
// - UART start condition starts UART boot loader.
// - Valid CAN dominant bit starts CAN boot.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

module boot_mode_selector (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Reset pin and configuration port.
  input  wire logic                     external_reset_input,
  input  wire logic [7:0]               boot_config_port_low,
  // Boot receive lines.
  input  wire logic                     uart0_receive_line,
  input  wire logic                     can1_receive_line,
  // Flash read port.
  output logic                          flash_rd_req,
  output logic [`FLASH_ADDR_W-1:0]      flash_rd_addr,
  input  wire logic [`FLASH_DATA_W-1:0] flash_rd_data,
  input  wire logic                     flash_rd_valid,
  // Mode and boot status.
  output logic [1:0]                    boot_mode,
  output logic                          code_fetch_test_flash,
  output logic                          config_reserved,
  output logic                          sw_reset_pulse,
  output logic                          user_code_run,
  output logic                          uart_boot_active,
  output logic                          can_boot_active,
  output logic                          boot_halted
);

  localparam logic [`LOW_CNT_W-1:0] UART_LOW = `LOW_CNT_W'(`UART_START_CYC);
  localparam logic [`LOW_CNT_W-1:0] CAN_LOW  = `LOW_CNT_W'(`CAN_DOMINANT_CYC);

  boot_mode_pkg::seq_state_e state_ff;
  boot_mode_pkg::seq_state_e nxt_state;
  logic                      rst_pin_ff;
  logic                      rst_rise;
  logic [1:0]                cfg_code_ff;
  logic                      uart_en_ff;
  logic                      can_en_ff;
  logic                      nxt_uart_en;
  logic                      nxt_can_en;
  logic                      uart_det;
  logic                      can_det;
  logic                      chk_start_ff;

  sig_check_if chk_bus ();

  // ==================================================================
  // Reset pin edge and configuration capture.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_pin_ff <= 1'b0;
    end else begin
      rst_pin_ff <= external_reset_input;
    end
  end

  assign rst_rise = external_reset_input && !rst_pin_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_code_ff <= `CFG_USER;
    end else if (rst_rise) begin
      cfg_code_ff <= boot_config_port_low[`CFG_HI_BIT:`CFG_LO_BIT];
    end
  end

  // ==================================================================
  // Channel detectors.
  line_start_detector #(.MIN_LOW(UART_LOW)) u_uart_det (
    .clk      (clk),
    .reset    (reset),
    .enable   (uart_en_ff && (state_ff == boot_mode_pkg::ST_SCAN)),
    .rx_line  (uart0_receive_line),
    .detected (uart_det)
  );

  line_start_detector #(.MIN_LOW(CAN_LOW)) u_can_det (
    .clk      (clk),
    .reset    (reset),
    .enable   (can_en_ff && (state_ff == boot_mode_pkg::ST_SCAN)),
    .rx_line  (can1_receive_line),
    .detected (can_det)
  );

  // ==================================================================
  // Signature checker.
  signature_checker u_sig_chk (
    .clk            (clk),
    .reset          (reset),
    .ctl            (chk_bus.chk),
    .flash_rd_req   (flash_rd_req),
    .flash_rd_addr  (flash_rd_addr),
    .flash_rd_data  (flash_rd_data),
    .flash_rd_valid (flash_rd_valid)
  );

  assign chk_bus.start = chk_start_ff;

  // ==================================================================
  // Boot sequencer.
  always_comb begin
    nxt_state   = state_ff;
    nxt_uart_en = uart_en_ff;
    nxt_can_en  = can_en_ff;
    unique case (state_ff)
      boot_mode_pkg::ST_WAIT_RST: begin
        if (rst_rise) begin
          nxt_state = boot_mode_pkg::ST_DECODE;
        end
      end
      boot_mode_pkg::ST_DECODE: begin
        unique case (cfg_code_ff)
          `CFG_USER:     nxt_state = boot_mode_pkg::ST_USER_RUN;
          `CFG_STD_BOOT: begin
            nxt_state   = boot_mode_pkg::ST_SCAN;
            nxt_uart_en = 1'b1;
            nxt_can_en  = 1'b1;
          end
          `CFG_SEL_BOOT: nxt_state = boot_mode_pkg::ST_SIG_CHECK;
          `CFG_RESERVED: nxt_state = boot_mode_pkg::ST_RESERVED;
        endcase
      end
      boot_mode_pkg::ST_SIG_CHECK: begin
        if (chk_bus.done && chk_bus.pass) begin
          nxt_state = boot_mode_pkg::ST_SW_RESET;
        end else if (chk_bus.done) begin
          nxt_state = boot_mode_pkg::ST_SCAN;
          unique case (chk_bus.key)
            `KEY_STD_BOOT: begin
              nxt_uart_en = 1'b1;
              nxt_can_en  = 1'b1;
            end
            `KEY_UART_ONLY: nxt_uart_en = 1'b1;
            `KEY_CAN_ONLY:  nxt_can_en  = 1'b1;
            default:        nxt_state = boot_mode_pkg::ST_HALT_LOOP;
          endcase
        end
      end
      boot_mode_pkg::ST_SCAN: begin
        if (uart_det) begin
          nxt_state  = boot_mode_pkg::ST_UART_BOOT;
          nxt_can_en = 1'b0;
        end else if (can_det) begin
          nxt_state   = boot_mode_pkg::ST_CAN_BOOT;
          nxt_uart_en = 1'b0;
        end
      end
      boot_mode_pkg::ST_SW_RESET: nxt_state = boot_mode_pkg::ST_USER_RUN;
      boot_mode_pkg::ST_UART_BOOT,
      boot_mode_pkg::ST_CAN_BOOT,
      boot_mode_pkg::ST_USER_RUN,
      boot_mode_pkg::ST_HALT_LOOP,
      boot_mode_pkg::ST_RESERVED: nxt_state = state_ff;
      default: nxt_state = boot_mode_pkg::ST_WAIT_RST;
    endcase
    if (!external_reset_input) begin
      nxt_state   = boot_mode_pkg::ST_WAIT_RST;
      nxt_uart_en = 1'b0;
      nxt_can_en  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff   <= boot_mode_pkg::ST_WAIT_RST;
      uart_en_ff <= 1'b0;
      can_en_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      uart_en_ff <= nxt_uart_en;
      can_en_ff  <= nxt_can_en;
    end
  end

  // Start pulse to the checker on entry to the signature check.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chk_start_ff <= 1'b0;
    end else begin
      chk_start_ff <= (state_ff == boot_mode_pkg::ST_DECODE) &&
                      (nxt_state == boot_mode_pkg::ST_SIG_CHECK);
    end
  end

  // ==================================================================
  // Registered status outputs.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_mode <= `CFG_USER;
    end else if (state_ff == boot_mode_pkg::ST_DECODE) begin
      boot_mode <= cfg_code_ff;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      code_fetch_test_flash <= 1'b0;
      config_reserved       <= 1'b0;
      sw_reset_pulse        <= 1'b0;
      user_code_run         <= 1'b0;
      uart_boot_active      <= 1'b0;
      can_boot_active       <= 1'b0;
      boot_halted           <= 1'b0;
    end else begin
      code_fetch_test_flash <= (nxt_state == boot_mode_pkg::ST_SIG_CHECK) ||
                               (nxt_state == boot_mode_pkg::ST_SW_RESET) ||
                               (nxt_state == boot_mode_pkg::ST_SCAN) ||
                               (nxt_state == boot_mode_pkg::ST_UART_BOOT) ||
                               (nxt_state == boot_mode_pkg::ST_CAN_BOOT) ||
                               (nxt_state == boot_mode_pkg::ST_HALT_LOOP);
      config_reserved       <= nxt_state == boot_mode_pkg::ST_RESERVED;
      sw_reset_pulse        <= nxt_state == boot_mode_pkg::ST_SW_RESET;
      user_code_run         <= nxt_state == boot_mode_pkg::ST_USER_RUN;
      uart_boot_active      <= nxt_state == boot_mode_pkg::ST_UART_BOOT;
      can_boot_active       <= nxt_state == boot_mode_pkg::ST_CAN_BOOT;
      boot_halted           <= nxt_state == boot_mode_pkg::ST_HALT_LOOP;
    end
  end

  // ==================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_pass_seen;
    chk_bus.done && chk_bus.pass && external_reset_input &&
    state_ff == boot_mode_pkg::ST_SIG_CHECK;
  endsequence

  sequence s_reset_then_run;
    sw_reset_pulse ##1 (user_code_run && !sw_reset_pulse);
  endsequence

  chk_capture_code: assert property (
    rst_rise |=> cfg_code_ff == $past(boot_config_port_low[5:4]))
    else $error("configuration code not latched at reset release");

  chk_user_map: assert property (
    user_code_run |-> !code_fetch_test_flash)
    else $error("user mode fetching from test flash");

  chk_std_entry: assert property (
    external_reset_input && state_ff == boot_mode_pkg::ST_DECODE &&
    cfg_code_ff == `CFG_STD_BOOT
    |=> code_fetch_test_flash && uart_en_ff && can_en_ff)
    else $error("standard boot entry wrong");

  chk_sel_start: assert property (
    external_reset_input && state_ff == boot_mode_pkg::ST_DECODE &&
    cfg_code_ff == `CFG_SEL_BOOT |=> chk_start_ff)
    else $error("selective boot did not start the check");

  chk_reserved_code: assert property (
    external_reset_input && state_ff == boot_mode_pkg::ST_DECODE &&
    cfg_code_ff == `CFG_RESERVED |=> config_reserved && !user_code_run)
    else $error("reserved code not flagged");

  chk_pass_runs: assert property (
    s_pass_seen |=> s_reset_then_run)
    else $error("good signature did not reset then run user code");

  chk_key_uart: assert property (
    external_reset_input && chk_bus.done && !chk_bus.pass &&
    state_ff == boot_mode_pkg::ST_SIG_CHECK &&
    chk_bus.key == `KEY_UART_ONLY |=> uart_en_ff && !can_en_ff)
    else $error("uart-only key enabled wrong channels");

  chk_key_loop: assert property (
    external_reset_input && chk_bus.done && !chk_bus.pass &&
    state_ff == boot_mode_pkg::ST_SIG_CHECK &&
    chk_bus.key != `KEY_STD_BOOT && chk_bus.key != `KEY_UART_ONLY &&
    chk_bus.key != `KEY_CAN_ONLY |=> boot_halted)
    else $error("unknown key did not halt");

  chk_uart_start: assert property (
    external_reset_input && uart_det |=> uart_boot_active && !can_boot_active)
    else $error("uart start not taken");

  chk_can_start: assert property (
    external_reset_input && can_det && !uart_det |=> can_boot_active)
    else $error("can dominant bit not taken");

  chk_channel_lock: assert property (
    uart_boot_active && external_reset_input |=> !can_boot_active)
    else $error("second channel taken after lock");

endmodule : boot_mode_selector

// ===== sim/signature_flash_model.sv
// Behavioural flash read port holding the signature and key words.
// Assumes the requester holds req and addr until a valid pulse.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

module signature_flash_model (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Read port.
  input  wire logic                     rd_req,
  input  wire logic [`FLASH_ADDR_W-1:0] rd_addr,
  output logic [`FLASH_DATA_W-1:0]      rd_data,
  output logic                          rd_valid,
  // Programmed contents and answer delay.
  input  wire logic [`FLASH_DATA_W-1:0] sig_word0,
  input  wire logic [`FLASH_DATA_W-1:0] sig_word1,
  input  wire logic [`FLASH_DATA_W-1:0] key_word,
  input  wire logic [1:0]               delay
);
  logic [1:0] wait_ff;

  // ==================================================================
  // Answers a held request once the delay loaded at the previous answer runs out; data toggles otherwise.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0;
      wait_ff  <= 2'h0;
    end else begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
      if (rd_req && !rd_valid) begin
        if (wait_ff == 2'h0) begin
          rd_valid <= 1'b1;
          wait_ff  <= delay;
          case (rd_addr)
            `SIG_ADDR0: rd_data <= sig_word0;
            `SIG_ADDR1: rd_data <= sig_word1;
            `KEY_ADDR:  rd_data <= key_word;
            default:    rd_data <= ~rd_data;
          endcase
        end else begin
          wait_ff <= wait_ff - 2'h1;
        end
      end
    end
  end
endmodule : signature_flash_model

// ===== sim/boot_mode_selector_tb.sv
// Self-checking bench for the boot mode selector.
// Assumes the flash model and the design files are compiled first.
`timescale 1ns/1ps
`include "boot_mode_consts.svh"

module boot_mode_selector_tb;
  logic        clk, reset, rst_pin, uart, can, req, rvalid;
  logic [7:0]  cfg;
  logic [15:0] w0, w1, wk, rdata;
  logic [1:0]  dly, mode;
  logic [23:0] addr;
  logic        tfl, rsv, swr, run, ua, ca, halt;
  logic [23:0] seen_q[$];
  int          failures, checks, pulses;

  boot_mode_selector boot_mode_selector_inst (
    .clk(clk), .reset(reset), .external_reset_input(rst_pin),
    .boot_config_port_low(cfg), .uart0_receive_line(uart),
    .can1_receive_line(can), .flash_rd_req(req), .flash_rd_addr(addr),
    .flash_rd_data(rdata), .flash_rd_valid(rvalid), .boot_mode(mode),
    .code_fetch_test_flash(tfl), .config_reserved(rsv),
    .sw_reset_pulse(swr), .user_code_run(run), .uart_boot_active(ua),
    .can_boot_active(ca), .boot_halted(halt));

  signature_flash_model signature_flash_model_inst (
    .clk(clk), .reset(reset), .rd_req(req), .rd_addr(addr),
    .rd_data(rdata), .rd_valid(rvalid), .sig_word0(w0), .sig_word1(w1),
    .key_word(wk), .delay(dly));

  // ==================================================================
  // Clock, pulse counter and read address log.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (swr === 1'b1) pulses++;
    if (rvalid === 1'b1 && req === 1'b1) seen_q.push_back(addr);
  end

  // ==================================================================
  // Helpers.
  function automatic logic [15:0] swap(input logic [15:0] x);
    return {x[7:0], x[15:8]};
  endfunction : swap

  function automatic logic [2:0] mode_flags(input logic [1:0] code);
    case (code)
      2'h3:    return 3'h4;
      2'h2:    return 3'h2;
      2'h0:    return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : mode_flags

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // Drops the pin, sets the code and raises the pin with it stable.
  task automatic boot(input logic [1:0] code);
    rst_pin = 1'b0;
    step(2);
    cfg = (8'($urandom) & 8'hcf) | {2'h0, code, 4'h0};
    dly = 2'($urandom);
    rst_pin = 1'b1;
    step(1);
    cfg = 8'($urandom);
    step(2);
  endtask : boot

  // Host holds a receive line low for n cycles.
  task automatic pulse(input bit on_uart, input int n);
    if (on_uart) uart = 1'b0;
    else can = 1'b0;
    step(n);
    uart = 1'b1;
    can  = 1'b1;
    step(1);
  endtask : pulse

  // Selective boot run up to the end of the flash reads.
  task automatic selb(input logic [15:0] a, b, k);
    int i;
    w0 = a;
    w1 = b;
    wk = k;
    pulses = 0;
    seen_q.delete();
    boot(2'h1);
    check(24'(mode), 24'h1);
    for (i = 0; i < 20 && req !== 1'b1; i++) step(1);
    for (i = 0; i < 100 && req === 1'b1; i++) step(1);
    step(3);
    check(seen_q[0], `SIG_ADDR0);
    check(seen_q[1], `SIG_ADDR1);
  endtask : selb

  // ==================================================================
  // Watchdog.
  initial begin
    #1500000;
    failures++;
    tally_and_finish();
  end

  // ==================================================================
  // Tests.
  initial begin
    logic [15:0] a, k;
    reset = 1'b1; rst_pin = 1'b0; cfg = 8'h0; uart = 1'b1; can = 1'b1;
    w0 = 16'h0; w1 = 16'h0; wk = 16'h0; dly = 2'h0;
    failures = 0; checks = 0; pulses = 0;
    void'($urandom(32'h73341d26));
    repeat (20) @(posedge clk);
    #1 reset = 1'b0;
    step(2);
    for (int c = 0; c < 4; c++) begin
      boot(2'(c));
      check(24'(mode), 24'(c));
      if (c != 1) check(24'({run, tfl, rsv}), 24'(mode_flags(2'(c))));
    end
    $display("test mode decode done");
    boot(2'h2);
    pulse(1, 19);
    check(24'(ua), 24'h0);
    pulse(1, 25);
    check(24'(ua), 24'h1);
    pulse(0, 45);
    check(24'({ca, tfl}), 24'h1);
    $display("test uart boot done");
    boot(2'h2);
    check(24'(tfl), 24'h1);
    pulse(0, 39);
    check(24'(ca), 24'h0);
    pulse(0, 45);
    check(24'(ca), 24'h1);
    pulse(1, 30);
    check(24'(ua), 24'h0);
    $display("test can boot done");
    for (int n = 0; n < 3; n++) begin
      a = 16'($urandom);
      selb(a, swap(a ^ `SIG_REFERENCE), 16'($urandom));
      check(24'(seen_q.size()), 24'h2);
      check(24'(pulses), 24'h1);
      check(24'({run, tfl, halt}), 24'h4);
    end
    $display("test good signature done");
    for (int n = 1; n < 5; n++) begin
      a = 16'($urandom);
      k = (n < 4) ? 16'(n) : 16'h4 + 16'($urandom_range(0, 8));
      selb(a, swap(a ^ `SIG_REFERENCE) ^ 16'h0100, k);
      check(seen_q[2], `KEY_ADDR);
      check(24'({run, pulses[0]}), 24'h0);
      case (n)
        1: pulse(0, 45);
        2: begin
          pulse(0, 45);
          check(24'(ca), 24'h0);
          pulse(1, 25);
        end
        3: begin
          pulse(1, 25);
          check(24'(ua), 24'h0);
          pulse(0, 45);
        end
        default: pulse(1, 25);
      endcase
      check(24'({ua, ca, halt}),
            (n == 2) ? 24'h4 : (n == 4) ? 24'h1 : 24'h2);
    end
    $display("test key actions done");
    boot(2'h3);
    rst_pin = 1'b0;
    step(2);
    check(24'({run, mode}), 24'h3);
    $display("test pin abort done");
    tally_and_finish();
  end
endmodule : boot_mode_selector_tb
